// ---- csa_regs.svh ----
`ifndef CSA_REGS_SVH
`define CSA_REGS_SVH
// ----------------------------------------
// timing counts
// ----------------------------------------
`define CSA_CLK_MHZ 200
`define CSA_RAMP_STD_MS 600
`define CSA_RAMP_FAST_MS 250
`define CSA_RAMP_STD_CYC (`CSA_RAMP_STD_MS * 1000 * `CSA_CLK_MHZ)
`define CSA_RAMP_FAST_CYC (`CSA_RAMP_FAST_MS * 1000 * `CSA_CLK_MHZ)
// ----------------------------------------
// fault codes and reset values
// ----------------------------------------
`define CSA_FAULT_HIGH 8'h14
`define CSA_FAULT_LOW 8'h17
`define CSA_FAULT_NONE 8'h00
`define CSA_LEVEL_W 16
`define CSA_LEVEL_ZERO 16'h0000
`define CSA_LEVEL_MAX 16'hffff
`define CSA_KNOB_FINE 16'h0001
`define CSA_KNOB_NORMAL 16'h0010
`endif

// ---- csa_pkg.sv ----
package csa_pkg;
	typedef enum logic [2:0] {
		CSA_L_PWR = 3'b001,
		CSA_L_VOLT = 3'b010,
		CSA_L_CUR = 3'b100
	} csa_lview_t;
	typedef enum logic [4:0] {
		CSA_R_PWR = 5'b00001,
		CSA_R_VOLT = 5'b00010,
		CSA_R_CUR = 5'b00100,
		CSA_R_ENERGY = 5'b01000,
		CSA_R_MIN = 5'b10000
	} csa_rview_t;
	typedef enum logic [2:0] {
		CSA_REG_PWR = 3'b001,
		CSA_REG_VOLT = 3'b010,
		CSA_REG_CUR = 3'b100
	} csa_regm_t;
	typedef enum logic [3:0] {
		CSA_RS_IDLE = 4'b0001,
		CSA_RS_RAMP = 4'b0010,
		CSA_RS_PAUSE = 4'b0100,
		CSA_RS_HOLD = 4'b1000
	} csa_ramp_t;
	typedef enum logic [2:0] {
		CSA_K_OFF = 3'b001,
		CSA_K_LOCK = 3'b010,
		CSA_K_PROGRAM_MODE = 3'b100
	} csa_key_t;
	// what the right meter is showing
	typedef enum logic [2:0] {
		CSA_RD_ACTUAL = 3'd0,
		CSA_RD_SETPT = 3'd1,
		CSA_RD_RAMP = 3'd2,
		CSA_RD_CONFIG = 3'd3,
		CSA_RD_REV = 3'd4,
		CSA_RD_TARGET = 3'd5,
		CSA_RD_RUN = 3'd6
	} csa_rdsp_t;
	// owner of a function
	typedef enum logic [1:0] {
		CSA_OWN_PANEL = 2'd0,
		CSA_OWN_HOST = 2'd1,
		CSA_OWN_USER = 2'd2
	} csa_own_t;
endpackage : csa_pkg

// ---- csa_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csa_regs.svh"
module csa_arbiter
	import csa_pkg::*;
#(
	parameter int unsigned RAMP_STD_CYC = `CSA_RAMP_STD_CYC,
	parameter int unsigned RAMP_FAST_CYC = `CSA_RAMP_FAST_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// panel keys, one-cycle press and release pulses
	input wire logic key_off_press,
	input wire logic key_off_release,
	input wire logic key_on_press,
	input wire logic key_ldisp_press,
	input wire logic key_rdisp_press,
	input wire logic key_host_press,
	input wire logic key_rlevel_press,
	input wire logic key_rramp_press,
	input wire logic key_ron_press,
	input wire logic key_power_press,
	input wire logic key_current_press,
	input wire logic key_level_press,
	// panel keys, held levels
	input wire logic key_test_held,
	input wire logic key_level_held,
	input wire logic key_ramp_held,
	input wire logic key_setpt_held,
	input wire logic key_power_held,
	input wire logic key_current_held,
	input wire logic key_fine,
	// knob, signed steps per pulse
	input wire logic knob_step,
	input wire logic knob_up,
	// mode key switch
	input wire logic mode_off,
	input wire logic mode_lock,
	// interlocks and user port
	input wire logic interlocks_ok,
	input wire logic user_off_closed,
	input wire logic user_on_closed,
	input wire logic estop_in,
	input wire logic estop_return_closed,
	input wire logic user_level_connected,
	input wire logic [`CSA_LEVEL_W-1:0] user_level,
	input wire logic user_ramp_connected,
	input wire logic [`CSA_LEVEL_W-1:0] user_ramp,
	input wire logic [2:0] user_regm,
	// host port
	input wire logic host_ready_common,
	input wire logic host_on_req,
	input wire logic host_off_req,
	// status inputs
	input wire logic bus_over,
	input wire logic bus_under,
	input wire logic energy_kwh_tick,
	input wire logic fast_ramp_opt,
	input wire logic setpt_reached,
	// outputs
	output logic output_on_q,
	output logic contactor_closed_q,
	output logic flash_latch_q,
	output logic [7:0] fault_code_q,
	output logic show_off_q,
	output logic estop_block_q,
	output logic test_leds_q,
	output logic test_keys_q,
	output logic [2:0] lview_q,
	output logic [4:0] rview_q,
	output logic [2:0] rdsp_q,
	output logic [2:0] regm_q,
	output logic [1:0] own_level_q,
	output logic [1:0] own_ramp_q,
	output logic [1:0] own_onoff_q,
	output logic host_ctl_q,
	output logic user_level_q,
	output logic user_ramp_q,
	output logic user_on_q,
	output logic [`CSA_LEVEL_W-1:0] setpoint_q,
	output logic [`CSA_LEVEL_W-1:0] ramp_time_q,
	output logic [`CSA_LEVEL_W-1:0] level_out_q,
	output logic [3:0] ramp_state_q,
	output logic level_flash_q,
	output logic [`CSA_LEVEL_W-1:0] energy_left_q,
	output logic interlock_reset_q
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// saturating knob step, used for setpoint, ramp and output level
	function automatic logic [`CSA_LEVEL_W-1:0] knob_apply(
		input logic [`CSA_LEVEL_W-1:0] v, input logic up, input logic fine);
		logic [`CSA_LEVEL_W:0] s;
		logic [`CSA_LEVEL_W-1:0] st;
		st = fine ? `CSA_KNOB_FINE : `CSA_KNOB_NORMAL;
		if (up) begin
			s = {1'b0, v} + {1'b0, st};
			knob_apply = s[`CSA_LEVEL_W] ? `CSA_LEVEL_MAX
				: s[`CSA_LEVEL_W-1:0];
		end else begin
			knob_apply = (v < st) ? `CSA_LEVEL_ZERO : v - st;
		end
	endfunction : knob_apply

	// default owner by fixed priority
	function automatic logic [1:0] owner(input logic user, input logic host);
		if (user)
			owner = CSA_OWN_USER;
		else if (host)
			owner = CSA_OWN_HOST;
		else
			owner = CSA_OWN_PANEL;
	endfunction : owner

	// ----------------------------------------
	// qualifiers
	// ----------------------------------------
	logic active;
	logic program_mode;
	logic panel_on;
	logic off_clear_ok;
	logic on_allowed;
	logic [31:0] ramp_def_cyc;
	logic [31:0] ramp_cnt_q;
	logic mode_off_q;

	assign active = !mode_off;
	assign program_mode = active && !mode_lock;
	assign panel_on = !user_on_q && !host_ctl_q;
	// latch clears only with off input closed and interlocks met
	assign off_clear_ok = user_off_closed && interlocks_ok;
	assign on_allowed = active && interlocks_ok && !flash_latch_q
		&& !estop_block_q && !estop_in && fault_code_q == `CSA_FAULT_NONE;
	assign ramp_def_cyc = fast_ramp_opt ? RAMP_FAST_CYC : RAMP_STD_CYC;

	// ----------------------------------------
	// mode tracking and off display
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_off_q <= 1'b1;
			show_off_q <= 1'b1;
		end else begin
			mode_off_q <= mode_off;
			show_off_q <= mode_off;
		end
	end

	// ----------------------------------------
	// flash latch: set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			flash_latch_q <= 1'b1;
		end else if ((mode_off_q && active)
			|| (key_host_press && program_mode && host_ctl_q)
			|| (key_ron_press && program_mode && user_on_q)) begin
			flash_latch_q <= 1'b1;
		end else if (key_off_press && active && off_clear_ok) begin
			flash_latch_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// emergency stop
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			estop_block_q <= 1'b0;
		end else if (estop_in) begin
			estop_block_q <= 1'b1;
		end else if (key_off_press && estop_return_closed) begin
			estop_block_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// bus voltage faults, a new event wins over the clearing press
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_code_q <= `CSA_FAULT_NONE;
		end else if (bus_over) begin
			fault_code_q <= `CSA_FAULT_HIGH;
		end else if (bus_under) begin
			fault_code_q <= `CSA_FAULT_LOW;
		end else if (key_off_press) begin
			fault_code_q <= `CSA_FAULT_NONE;
		end
	end

	// ----------------------------------------
	// control site ownership
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			host_ctl_q <= 1'b0;
			user_level_q <= 1'b0;
			user_ramp_q <= 1'b0;
			user_on_q <= 1'b0;
		end else if (program_mode) begin
			// lock mode freezes the control site
			if (key_host_press) begin
				if (host_ctl_q)
					host_ctl_q <= 1'b0;
				else if (host_ready_common)
					host_ctl_q <= 1'b1;
			end
			if (key_rlevel_press)
				user_level_q <= !user_level_q;
			if (key_rramp_press)
				user_ramp_q <= !user_ramp_q;
			if (key_ron_press)
				user_on_q <= !user_on_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			own_level_q <= CSA_OWN_PANEL;
			own_ramp_q <= CSA_OWN_PANEL;
			own_onoff_q <= CSA_OWN_PANEL;
		end else begin
			own_level_q <= owner(user_level_q, host_ctl_q);
			own_ramp_q <= owner(user_ramp_q, host_ctl_q);
			own_onoff_q <= owner(user_on_q, host_ctl_q);
		end
	end

	// ----------------------------------------
	// output on/off and contactor
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			output_on_q <= 1'b0;
			contactor_closed_q <= 1'b0;
			interlock_reset_q <= 1'b0;
		end else begin
			interlock_reset_q <= key_off_press && interlocks_ok;
			contactor_closed_q <= !estop_in && !estop_block_q;
			if (!on_allowed || key_off_press) begin
				output_on_q <= 1'b0;
			end else if (key_on_press && panel_on) begin
				output_on_q <= 1'b1;
			end else if (host_ctl_q && !user_on_q) begin
				if (host_off_req)
					output_on_q <= 1'b0;
				else if (host_on_req)
					output_on_q <= 1'b1;
			end else if (user_on_q) begin
				// two-wire: closed inputs turn on again once off is let go
				if (!user_off_closed)
					output_on_q <= 1'b0;
				else if (user_on_closed && (key_off_release
					|| !key_off_press))
					output_on_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// regulation method
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			regm_q <= CSA_REG_PWR;
		end else if (user_level_q) begin
			regm_q <= user_regm;
		end else if (program_mode && !host_ctl_q
			&& (key_power_press || key_current_press)) begin
			if ((key_power_press || key_power_held)
				&& (key_current_press || key_current_held))
				regm_q <= CSA_REG_VOLT;
			else if (key_power_press)
				regm_q <= CSA_REG_PWR;
			else
				regm_q <= CSA_REG_CUR;
		end
	end

	// ----------------------------------------
	// setpoint and ramp time programming
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			setpoint_q <= `CSA_LEVEL_ZERO;
		end else if (user_level_q) begin
			setpoint_q <= user_level_connected ? user_level
				: `CSA_LEVEL_ZERO;
		end else if (program_mode && !host_ctl_q && key_level_held && knob_step) begin
			setpoint_q <= knob_apply(setpoint_q, knob_up, key_fine);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ramp_time_q <= `CSA_LEVEL_ZERO;
		end else if (user_ramp_q) begin
			ramp_time_q <= user_ramp_connected ? user_ramp
				: `CSA_LEVEL_ZERO;
		end else if (program_mode && !host_ctl_q && key_ramp_held && knob_step) begin
			ramp_time_q <= knob_apply(ramp_time_q, knob_up, key_fine);
		end
	end

	// ----------------------------------------
	// ramp sequencer: default ramp when no time is programmed
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ramp_state_q <= CSA_RS_IDLE;
			ramp_cnt_q <= '0;
			level_out_q <= `CSA_LEVEL_ZERO;
			level_flash_q <= 1'b0;
		end else if (!output_on_q) begin
			ramp_state_q <= CSA_RS_IDLE;
			ramp_cnt_q <= '0;
			level_out_q <= `CSA_LEVEL_ZERO;
			level_flash_q <= 1'b0;
		end else begin
			unique case (ramp_state_q)
			CSA_RS_IDLE: begin
				ramp_state_q <= CSA_RS_RAMP;
				ramp_cnt_q <= '0;
			end
			CSA_RS_RAMP: begin
				// programmed ramps are timed elsewhere; here only the default
				if (key_level_press && active) begin
					ramp_state_q <= CSA_RS_PAUSE;
					level_flash_q <= 1'b1;
				end else if (setpt_reached || (ramp_time_q == `CSA_LEVEL_ZERO
					&& ramp_cnt_q >= ramp_def_cyc - 32'd1)) begin
					ramp_state_q <= CSA_RS_HOLD;
					level_out_q <= setpoint_q;
				end else begin
					ramp_cnt_q <= ramp_cnt_q + 32'd1;
				end
			end
			CSA_RS_PAUSE: begin
				if (key_level_press) begin
					ramp_state_q <= CSA_RS_RAMP;
					level_flash_q <= 1'b0;
				end else if (knob_step && active) begin
					level_out_q <= knob_apply(level_out_q, knob_up,
						key_fine);
				end
			end
			CSA_RS_HOLD: begin
				if (knob_step && active && !key_level_held)
					level_out_q <= knob_apply(level_out_q, knob_up,
						key_fine);
			end
			default: ramp_state_q <= CSA_RS_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// displays and test
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			lview_q <= CSA_L_PWR;
			rview_q <= CSA_R_PWR;
		end else if (active) begin
			if (key_ldisp_press)
				lview_q <= {lview_q[1:0], lview_q[2]};
			if (key_rdisp_press)
				rview_q <= {rview_q[3:0], rview_q[4]};
		end
	end

	// sticky setpoint display, dropped by the right display key
	logic setpt_latched_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			setpt_latched_q <= 1'b0;
		end else if (key_rdisp_press) begin
			setpt_latched_q <= 1'b0;
		end else if (key_setpt_held && key_level_press) begin
			setpt_latched_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdsp_q <= CSA_RD_ACTUAL;
		end else if (key_setpt_held && key_power_held && key_current_held) begin
			rdsp_q <= CSA_RD_REV;
		end else if (key_setpt_held && key_power_held) begin
			rdsp_q <= CSA_RD_CONFIG;
		end else if (key_ramp_held) begin
			rdsp_q <= CSA_RD_RAMP;
		end else if (key_setpt_held || setpt_latched_q) begin
			if (rview_q == CSA_R_ENERGY)
				rdsp_q <= CSA_RD_TARGET;
			else if (rview_q == CSA_R_MIN)
				rdsp_q <= CSA_RD_RUN;
			else
				rdsp_q <= CSA_RD_SETPT;
		end else begin
			rdsp_q <= CSA_RD_ACTUAL;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			test_leds_q <= 1'b0;
			test_keys_q <= 1'b0;
		end else begin
			test_leds_q <= active && key_test_held;
			test_keys_q <= active && key_test_held && !output_on_q;
		end
	end

	// remaining target life, whole kWh steps
	always_ff @(posedge clk) begin
		if (rst) begin
			energy_left_q <= `CSA_LEVEL_MAX;
		end else if (energy_kwh_tick && energy_left_q != `CSA_LEVEL_ZERO) begin
			energy_left_q <= energy_left_q - `CSA_KNOB_FINE;
		end
	end
endmodule : csa_arbiter
`default_nettype wire

// ---- csa_arbiter_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csa_regs.svh"
// ------------------------------
// arbiter port checks
// ------------------------------
module csa_arbiter_chk
	import csa_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// panel and wiring
	input wire logic key_on_press,
	input wire logic key_off_press,
	input wire logic key_host_press,
	input wire logic key_power_press,
	input wire logic key_current_press,
	input wire logic mode_off,
	input wire logic mode_lock,
	input wire logic interlocks_ok,
	input wire logic user_off_closed,
	input wire logic host_ready_common,
	input wire logic bus_over,
	input wire logic bus_under,
	input wire logic estop_in,
	// arbiter outputs
	input wire logic output_on_q,
	input wire logic contactor_closed_q,
	input wire logic flash_latch_q,
	input wire logic [7:0] fault_code_q,
	input wire logic estop_block_q,
	input wire logic [2:0] regm_q,
	input wire logic [1:0] own_level_q,
	input wire logic [1:0] own_onoff_q,
	input wire logic host_ctl_q,
	input wire logic user_on_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// key switch leaving off, one step at a time
	sequence s_left_off;
		mode_off ##1 !mode_off;
	endsequence
	// panel press able to change regulation
	sequence s_both_keys;
		key_power_press && key_current_press && !mode_off && !mode_lock
			&& own_level_q == CSA_OWN_PANEL;
	endsequence
	chk_on_gate: assert property ($rose(output_on_q)
		&& $past(own_onoff_q) == CSA_OWN_PANEL && !$past(host_ctl_q)
		&& !$past(user_on_q) |-> $past(key_on_press)
		&& !$past(flash_latch_q) && $past(interlocks_ok))
		else $error("panel turned output on without cause");
	chk_off_now: assert property (key_off_press |=> !output_on_q)
		else $error("off press left output on");
	chk_latch_clear: assert property ($fell(flash_latch_q) |->
		$past(key_off_press) && $past(user_off_closed)
		&& $past(interlocks_ok))
		else $error("flash latch cleared without qualified off");
	chk_fault_high: assert property (bus_over && !bus_under |=>
		fault_code_q == `CSA_FAULT_HIGH)
		else $error("bus over not reported");
	chk_fault_hold: assert property (fault_code_q != `CSA_FAULT_NONE
		&& !key_off_press && !bus_over && !bus_under |=>
		$stable(fault_code_q))
		else $error("fault code changed without off press");
	chk_estop_stop: assert property (estop_in |=> !output_on_q
		&& !contactor_closed_q && estop_block_q)
		else $error("emergency stop did not block output");
	chk_host_ready: assert property ($rose(host_ctl_q) |->
		$past(host_ready_common) && $past(key_host_press))
		else $error("host took control without ready");
	chk_host_back: assert property ($fell(host_ctl_q) |-> flash_latch_q)
		else $error("return from host did not set latch");
	chk_user_back: assert property ($fell(user_on_q) |-> flash_latch_q)
		else $error("return from user port did not set latch");
	chk_mode_leave: assert property (s_left_off |=> flash_latch_q)
		else $error("leaving off did not set latch");
	chk_lock_regm: assert property (mode_lock && !mode_off
		&& own_level_q != CSA_OWN_USER |=> $stable(regm_q))
		else $error("regulation changed in lock");
	chk_both_volt: assert property (s_both_keys |=>
		regm_q == CSA_REG_VOLT)
		else $error("both keys did not give voltage");
endmodule : csa_arbiter_chk
`default_nettype wire

// ---- csa_user_port.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// far side: user port and host
// ------------------------------
module csa_user_port (
	// clock
	input wire logic clk,
	// wiring chosen by the bench
	input wire logic off_wired,
	input wire logic on_wired,
	input wire logic ret_wired,
	input wire logic ready_wired,
	// lines seen by the arbiter
	output logic user_off_closed,
	output logic user_on_closed,
	output logic estop_return_closed,
	output logic host_ready_common,
	output logic user_level_connected,
	output logic [15:0] user_level,
	output logic user_ramp_connected,
	output logic [15:0] user_ramp,
	output logic [2:0] user_regm
);
	logic [15:0] float_q = 16'ha5c3;
	// contacts to interlock_common are plain closures
	assign user_off_closed = off_wired;
	assign user_on_closed = on_wired;
	assign estop_return_closed = ret_wired;
	assign host_ready_common = ready_wired;
	// analog inputs left open, so no steady level to trust
	assign user_level_connected = 1'b0;
	assign user_ramp_connected = 1'b0;
	assign user_level = float_q;
	assign user_ramp = ~float_q;
	assign user_regm = 3'b010;
	// open line wanders every cycle, away from the sampling edge
	always @(negedge clk)
		float_q <= float_q + 16'h1357;
endmodule : csa_user_port
`default_nettype wire

// ---- csa_arbiter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csa_regs.svh"
module csa_arbiter_tb;
	import csa_pkg::*;
	typedef struct packed {logic [3:0] k; logic [2:0] o; logic [15:0] e;} csa_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic key_off_press, key_off_release, key_on_press, key_ldisp_press;
	logic key_rdisp_press, key_host_press, key_rlevel_press, key_rramp_press;
	logic key_ron_press, key_power_press, key_current_press, key_level_press;
	logic key_test_held, key_level_held, key_ramp_held, key_setpt_held;
	logic key_power_held, key_current_held, key_fine, knob_step, knob_up;
	logic mode_off, mode_lock, interlocks_ok, estop_in, host_on_req;
	logic host_off_req, bus_over, bus_under, energy_kwh_tick;
	logic fast_ramp_opt, setpt_reached;
	logic off_wired, on_wired, ret_wired, ready_wired;
	logic user_off_closed, user_on_closed, estop_return_closed;
	logic host_ready_common, user_level_connected, user_ramp_connected;
	logic [15:0] user_level, user_ramp;
	logic [2:0] user_regm;
	logic output_on_q, contactor_closed_q, flash_latch_q, show_off_q;
	logic estop_block_q, test_leds_q, test_keys_q, host_ctl_q, user_level_q;
	logic user_ramp_q, user_on_q, level_flash_q, interlock_reset_q;
	logic [7:0] fault_code_q;
	logic [2:0] lview_q, rdsp_q, regm_q;
	logic [4:0] rview_q;
	logic [1:0] own_level_q, own_ramp_q, own_onoff_q;
	logic [15:0] setpoint_q, ramp_time_q, level_out_q, energy_left_q;
	logic [3:0] ramp_state_q;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	// key, observed group, expected value
	csa_row_t rows [0:17] = '{'{4'h0, 3'h0, 16'h2}, '{4'h0, 3'h0, 16'h4},
		'{4'h0, 3'h0, 16'h1}, '{4'h1, 3'h1, 16'h2}, '{4'h1, 3'h1, 16'h4},
		'{4'h1, 3'h1, 16'h8}, '{4'h1, 3'h1, 16'h10}, '{4'h1, 3'h1, 16'h1},
		'{4'h3, 3'h2, 16'h4}, '{4'h4, 3'h2, 16'h2}, '{4'h2, 3'h2, 16'h1},
		'{4'h5, 3'h3, 16'h4}, '{4'h6, 3'h3, 16'h6}, '{4'h5, 3'h3, 16'h2},
		'{4'h6, 3'h3, 16'h0}, '{4'hb, 3'h3, 16'h1}, '{4'hb, 3'h3, 16'h0},
		'{4'h7, 3'h4, 16'hfffe}};
	// ----------------------------
	// design, far side, checker
	// ----------------------------
	csa_arbiter #(.RAMP_STD_CYC(20), .RAMP_FAST_CYC(10)) u_csa_arbiter (.*);
	csa_user_port u_csa_user_port (.*);
	always #2.5 clk = ~clk;
	// hang guard, far above the roughly 140 cycles used
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic check(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// one-cycle press; outputs registered straight from the press have landed when it returns, own_* need one more cycle
	task automatic press(input logic [3:0] k);
		@(negedge clk);
		case (k)
		4'h0: key_ldisp_press = 1'b1;
		4'h1: key_rdisp_press = 1'b1;
		4'h2: key_power_press = 1'b1;
		4'h3: key_current_press = 1'b1;
		4'h4: {key_power_press, key_current_press} = 2'b11;
		4'h5: key_rlevel_press = 1'b1;
		4'h6: key_rramp_press = 1'b1;
		4'h7: energy_kwh_tick = 1'b1;
		4'h8: key_off_press = 1'b1;
		4'h9: key_on_press = 1'b1;
		4'ha: key_host_press = 1'b1;
		default: key_ron_press = 1'b1;
		endcase
		@(negedge clk);
		{key_ldisp_press, key_rdisp_press, key_power_press, key_current_press,
			key_rlevel_press, key_rramp_press, energy_kwh_tick, key_off_press,
			key_on_press, key_host_press, key_ron_press} = '0;
	endtask : press
	function automatic logic [15:0] obs(input logic [2:0] o);
		case (o)
		3'h0: obs = {13'h0, lview_q};
		3'h1: obs = {11'h0, rview_q};
		3'h2: obs = {13'h0, regm_q};
		3'h3: obs = {13'h0, user_level_q, user_ramp_q, user_on_q};
		default: obs = energy_left_q;
		endcase
	endfunction : obs
	// ----------------------------
	// main sequence
	// ----------------------------
	initial begin
		{key_off_press, key_off_release, key_on_press, key_ldisp_press,
			key_rdisp_press, key_host_press, key_rlevel_press, key_rramp_press,
			key_ron_press, key_power_press, key_current_press, key_level_press,
			key_test_held, key_level_held, key_ramp_held, key_setpt_held,
			key_power_held, key_current_held, key_fine, knob_step, knob_up,
			mode_off, mode_lock, interlocks_ok, estop_in, host_on_req,
			host_off_req, bus_over, bus_under, energy_kwh_tick, fast_ramp_opt,
			setpt_reached, on_wired, ready_wired} = '0;
		{off_wired, ret_wired} = 2'b11;
		repeat (3) @(negedge clk);
		check("latch in reset", 16'(flash_latch_q), 16'h1);
		check("energy in reset", energy_left_q, 16'hffff);
		check("owner in reset", 16'(own_onoff_q), 16'h0);
		rst = 1'b0;
		foreach (rows[i]) begin
			press(rows[i].k);
			check($sformatf("row %0d", i), obs(rows[i].o), rows[i].e);
		end
		check("open setpoint", setpoint_q, 16'h0);
		check("open ramp", ramp_time_q, 16'h0);
		// interlock, open off input, then a qualified off
		press(4'h9);
		check("on while latched", 16'(output_on_q), 16'h0);
		press(4'h8);
		check("latch interlock", 16'(flash_latch_q), 16'h1);
		interlocks_ok = 1'b1;
		off_wired = 1'b0;
		press(4'h8);
		check("latch off open", 16'(flash_latch_q), 16'h1);
		off_wired = 1'b1;
		press(4'h8);
		check("latch cleared", 16'(flash_latch_q), 16'h0);
		press(4'h9);
		check("panel on", 16'(output_on_q), 16'h1);
		press(4'h8);
		check("off press", 16'(output_on_q), 16'h0);
		// host handover needs the ready line
		press(4'ha);
		check("host no ready", 16'(host_ctl_q), 16'h0);
		ready_wired = 1'b1;
		press(4'ha);
		@(negedge clk);
		check("host owns", 16'(own_onoff_q), 16'h1);
		press(4'h9);
		check("on under host", 16'(output_on_q), 16'h0);
		host_on_req = 1'b1;
		@(negedge clk);
		host_on_req = 1'b0;
		host_off_req = 1'b1;
		check("host on", 16'(output_on_q), 16'h1);
		@(negedge clk);
		host_off_req = 1'b0;
		check("host off", 16'(output_on_q), 16'h0);
		press(4'ha);
		check("host back", 16'(flash_latch_q), 16'h1);
		press(4'h8);
		press(4'hb);
		@(negedge clk);
		check("user owns", 16'(own_onoff_q), 16'h2);
		on_wired = 1'b1;
		@(negedge clk);
		check("two-wire on", 16'(output_on_q), 16'h1);
		press(4'h8);
		check("off", 16'({output_on_q, interlock_reset_q}), 16'h1);
		@(negedge clk);
		check("rearm", 16'({output_on_q, interlock_reset_q}), 16'h2);
		on_wired = 1'b0;
		press(4'hb);
		check("user back", 16'(flash_latch_q), 16'h1);
		press(4'h8);
		// both bus faults, each held until off
		for (int i = 0; i < 2; i++) begin
			bus_over = (i == 0);
			bus_under = (i == 1);
			@(negedge clk);
			{bus_over, bus_under} = 2'b00;
			repeat (2) @(negedge clk);
			check("fault", 16'(fault_code_q),
				16'(i ? `CSA_FAULT_LOW : `CSA_FAULT_HIGH));
			press(4'h8);
			check("fault cleared", 16'(fault_code_q), 16'h0);
		end
		// emergency stop while on, release needs return closed
		press(4'h9);
		estop_in = 1'b1;
		@(negedge clk);
		check("estop", {14'h0, output_on_q, estop_block_q}, 16'h1);
		estop_in = 1'b0;
		ret_wired = 1'b0;
		press(4'h8);
		check("estop return open", 16'(estop_block_q), 16'h1);
		ret_wired = 1'b1;
		press(4'h8);
		check("estop reset", 16'(estop_block_q), 16'h0);
		key_test_held = 1'b1;
		repeat (2) @(negedge clk);
		check("test while off", 16'({test_leds_q, test_keys_q}), 16'h3);
		key_test_held = 1'b0;
		// knob, right meter views, then a paused default ramp
		{key_level_held, knob_step, knob_up} = 3'b111;
		@(negedge clk);
		key_fine = 1'b1;
		@(negedge clk);
		{key_level_held, knob_step, key_fine} = 3'b000;
		check("setpoint", setpoint_q, 16'h11);
		key_ramp_held = 1'b1;
		@(negedge clk);
		check("ramp view", 16'(rdsp_q), 16'h2);
		{key_ramp_held, key_setpt_held, key_power_held} = 3'b011;
		@(negedge clk);
		check("config view", 16'(rdsp_q), 16'h3);
		key_current_held = 1'b1;
		@(negedge clk);
		check("revision view", 16'(rdsp_q), 16'h4);
		{key_setpt_held, key_power_held, key_current_held} = 3'b100;
		@(negedge clk);
		check("setpoint view", 16'(rdsp_q), 16'h1);
		key_level_press = 1'b1;
		@(negedge clk);
		{key_setpt_held, key_level_press} = 2'b00;
		@(negedge clk);
		check("latched view", 16'(rdsp_q), 16'h1);
		press(4'h1);
		@(negedge clk);
		check("latch dropped", 16'(rdsp_q), 16'h0);
		press(4'h9);
		@(negedge clk);
		key_level_press = 1'b1;
		@(negedge clk);
		{key_level_press, knob_step} = 2'b01;
		@(negedge clk);
		knob_step = 1'b0;
		check("pause", 16'({level_flash_q, ramp_state_q}), 16'h14);
		check("pause knob", level_out_q, 16'h10);
		key_level_press = 1'b1;
		@(negedge clk);
		key_level_press = 1'b0;
		repeat (19) @(negedge clk);
		check("ramping", 16'(ramp_state_q), 16'h2);
		@(negedge clk);
		check("reached", level_out_q, 16'h11);
		knob_step = 1'b1;
		@(negedge clk);
		knob_step = 1'b0;
		check("hold knob", level_out_q, 16'h21);
		key_test_held = 1'b1;
		@(negedge clk);
		check("test while on", 16'({test_leds_q, test_keys_q}), 16'h2);
		key_test_held = 1'b0;
		// lock keeps regulation, off shows the word
		press(4'h2);
		mode_lock = 1'b1;
		press(4'h3);
		check("lock regulation", 16'(regm_q), 16'h1);
		mode_lock = 1'b0;
		mode_off = 1'b1;
		repeat (2) @(negedge clk);
		check("key off", 16'(show_off_q), 16'h1);
		mode_off = 1'b0;
		@(negedge clk);
		check("leave off", 16'(flash_latch_q), 16'h1);
		give_verdict();
	end
endmodule : csa_arbiter_tb
bind csa_arbiter csa_arbiter_chk u_csa_arbiter_chk (.*);
`default_nettype wire
